// ==== rtl/sdpf_consts.svh ====
// Constants for the DRAM pin control front end
// What this block does
// - Every input pin is captured only on the rising edge of the system clock.
// - The system clock advances the burst counter and loads the output registers.
// - Clock enable high lets the clock act inside; low stops it inside.
// - A stopped clock means precharge power-down or self refresh when idle, active power-down with a row open, clock suspend during a burst.
// - Clock enable is sampled synchronously, but only its return high matters once power-down or self refresh is entered.
// - Input buffers, clock buffer included, are off during power-down and self refresh.
// - Chip select registered low enables the command decoder; high masks every command.
// - With chip select high a running burst goes on and the data mask keeps working.
// - Row, column and write strobes with chip select, all active low, form the command decoded in its own cycle.
// - A write beat with its byte mask high leaves that byte of memory unchanged.
// - A read with its byte mask high turns that byte's drivers off two clocks later.
// - The low-byte mask governs data bits 7..0 and the high-byte mask bits 15..8.
// - The two bank address bits pick the bank for activate, read, write and precharge.
// - Precharge closes all banks with the auto precharge bit high, else only the addressed bank.
// - Activate takes the row from the address; read or write take the column from the low bits, bit 10 asking for auto precharge.
// - A mode register load takes its operation code from the address inputs.
`ifndef SDPF_CONSTS_SVH
`define SDPF_CONSTS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define SDPF_ROW_W     13
`define SDPF_COL_W     9
`define SDPF_DQ_W      16
`define SDPF_BANKS     4
`define SDPF_AP_BIT    10

// ------------------------------------------------------------
// Command codes as {select, row, column, write}, all active low
// ------------------------------------------------------------
`define SDPF_CODE_LMR  4'h0
`define SDPF_CODE_REF  4'h1
`define SDPF_CODE_PRE  4'h2
`define SDPF_CODE_ACT  4'h3
`define SDPF_CODE_WR   4'h4
`define SDPF_CODE_RD   4'h5
`define SDPF_CODE_BST  4'h6
`define SDPF_CODE_NOP  4'h7

// ------------------------------------------------------------
// Mode word burst length field and data path timing
// ------------------------------------------------------------
`define SDPF_BL_LSB    0
`define SDPF_BL_MSB    2
`define SDPF_BL_1      3'h0
`define SDPF_BL_2      3'h1
`define SDPF_BL_4      3'h2
`define SDPF_BL_8      3'h3
`define SDPF_BL_PAGE   3'h7
`define SDPF_MASK_LAT  2

`endif

// ==== rtl/sdpf_pkg.sv ====
// Types shared by the DRAM pin control front end
`default_nettype none
package sdpf_pkg;
    typedef enum logic [3:0] {
        SDPF_DESEL, SDPF_NOP, SDPF_ACT, SDPF_RD, SDPF_WR,
        SDPF_BST, SDPF_PRE, SDPF_REF, SDPF_LMR
    } sdpf_cmd_type;

    typedef enum logic [2:0] {
        SDPF_RUN, SDPF_PRE_PD, SDPF_ACT_PD, SDPF_SUSPEND, SDPF_SELF_REF
    } sdpf_pwr_type;
endpackage : sdpf_pkg
`default_nettype wire

// ==== rtl/sdpf_cmd_if.sv ====
// Decoded command path between decoder and core
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"

interface sdpf_cmd_if;
    import sdpf_pkg::*;
    sdpf_cmd_type            cmd;
    logic [1:0]              bank;
    logic [`SDPF_ROW_W-1:0]  addr;
    logic                    clk_act;

    modport dec  (output cmd, output bank, output addr, input clk_act);
    modport core (input cmd, input bank, input addr, output clk_act);
endinterface : sdpf_cmd_if

`default_nettype wire

// ==== rtl/sdpf_cmd_decode.sv ====
// Command pin register and decoder
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"

module sdpf_cmd_decode
    import sdpf_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    cs_n,
    input  wire logic                    ras_n,
    input  wire logic                    cas_n,
    input  wire logic                    we_n,
    input  wire logic [1:0]              ba,
    input  wire logic [`SDPF_ROW_W-1:0]  addr,
    sdpf_cmd_if.dec                      cmd_bus
);

    logic [3:0]              code_r;
    logic [3:0]              code_nxt;
    logic [1:0]              ba_r;
    logic [1:0]              ba_nxt;
    logic [`SDPF_ROW_W-1:0]  addr_r;
    logic [`SDPF_ROW_W-1:0]  addr_nxt;

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // rising edge capture
    always_comb begin
        code_nxt = {cs_n, ras_n, cas_n, we_n};
        ba_nxt   = ba;
        addr_nxt = addr;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            code_r <= `SDPF_CODE_NOP | 4'h8;
            ba_r   <= 2'h0;
            addr_r <= '0;
        end else begin
            code_r <= code_nxt;
            ba_r   <= ba_nxt;
            addr_r <= addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Decode of the registered strobes
    // ------------------------------------------------------------
    // joint strobe decode
    always_comb begin
        cmd_bus.bank = ba_r;
        cmd_bus.addr = addr_r;
        if (!cmd_bus.clk_act) begin
            cmd_bus.cmd = SDPF_NOP;
        end else if (code_r[3]) begin
            cmd_bus.cmd = SDPF_DESEL;
        end else begin
            case (code_r)
                `SDPF_CODE_LMR: cmd_bus.cmd = SDPF_LMR;
                `SDPF_CODE_REF: cmd_bus.cmd = SDPF_REF;
                `SDPF_CODE_PRE: cmd_bus.cmd = SDPF_PRE;
                `SDPF_CODE_ACT: cmd_bus.cmd = SDPF_ACT;
                `SDPF_CODE_WR:  cmd_bus.cmd = SDPF_WR;
                `SDPF_CODE_RD:  cmd_bus.cmd = SDPF_RD;
                `SDPF_CODE_BST: cmd_bus.cmd = SDPF_BST;
                default:        cmd_bus.cmd = SDPF_NOP;
            endcase
        end
    end

endmodule : sdpf_cmd_decode

`default_nettype wire

// ==== rtl/sdpf_dq_mask.sv ====
// Data lines, byte masks and read output enables
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"

module sdpf_dq_mask #(
    parameter int DQ_W = `SDPF_DQ_W
)(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [DQ_W/8-1:0]    mask_in,
    input  wire logic [DQ_W-1:0]      dq_in,
    input  wire logic                 rd_beat,
    input  wire logic [DQ_W-1:0]      arr_rdata,
    output logic      [DQ_W-1:0]      dq_out,
    output logic      [DQ_W/8-1:0]    dq_oe,
    output logic      [DQ_W-1:0]      wdata,
    output logic      [DQ_W/8-1:0]    wbe
);

    localparam int LANES = DQ_W / 8;

    logic [LANES-1:0]           mask_r;
    logic [LANES-1:0]           mask_d1_r;
    logic [DQ_W-1:0]            dq_r;
    logic [`SDPF_MASK_LAT-1:0]  rdv_r;
    logic [`SDPF_MASK_LAT-1:0]  rdv_nxt;
    logic [LANES-1:0]           oe_nxt;
    logic [LANES-1:0]           wbe_nxt;

    // ------------------------------------------------------------
    // Per-lane mask use
    // ------------------------------------------------------------
    // one mask per byte lane
    generate
        for (genvar i = 0; i < LANES; i++) begin : g_lane
            always_comb begin
                oe_nxt[i]  = rdv_r[`SDPF_MASK_LAT-1] & ~mask_d1_r[i];
                wbe_nxt[i] = ~mask_r[i];
            end
        end
    endgenerate

    // Read beat valid pipeline, matches array return
    always_comb begin
        rdv_nxt = {rdv_r[`SDPF_MASK_LAT-2:0], rd_beat};
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // mask runs regardless of select
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_r    <= '0;
            mask_d1_r <= '0;
            dq_r      <= '0;
            rdv_r     <= '0;
            dq_out    <= '0;
            dq_oe     <= '0;
            wdata     <= '0;
            wbe       <= '0;
        end else begin
            mask_r    <= mask_in;
            mask_d1_r <= mask_r;
            dq_r      <= dq_in;
            rdv_r     <= rdv_nxt;
            dq_out    <= arr_rdata;   // output register
            dq_oe     <= oe_nxt;
            wdata     <= dq_r;
            wbe       <= wbe_nxt;
        end
    end

endmodule : sdpf_dq_mask

`default_nettype wire

// ==== rtl/sdpf_front_end.sv ====
// Top of the DRAM pin control front end
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"

module sdpf_front_end
    import sdpf_pkg::*;
#(
    parameter int ROW_W = `SDPF_ROW_W,
    parameter int COL_W = `SDPF_COL_W,
    parameter int DQ_W  = `SDPF_DQ_W
)(
    input  wire logic                 MCLK,
    input  wire logic                 SRST,
    input  wire logic                 CKE,
    input  wire logic                 CS_N,
    input  wire logic                 RAS_N,
    input  wire logic                 CAS_N,
    input  wire logic                 WE_N,
    input  wire logic [1:0]           BA,
    input  wire logic [ROW_W-1:0]     A,
    input  wire logic                 LOWER_BYTE_MASK,
    input  wire logic                 UPPER_BYTE_MASK,
    input  wire logic [DQ_W-1:0]      DQ_I,
    output logic      [DQ_W-1:0]      DQ_O,
    output logic      [DQ_W/8-1:0]    DQ_OE,
    output logic                      ARR_RD,
    output logic                      ARR_WR,
    output logic                      ARR_REF,
    output logic      [1:0]           ARR_BANK,
    output logic      [ROW_W-1:0]     ARR_ROW,
    output logic      [COL_W-1:0]     ARR_COL,
    output logic      [DQ_W-1:0]      ARR_WDATA,
    output logic      [DQ_W/8-1:0]    ARR_WBE,
    input  wire logic [DQ_W-1:0]      ARR_RDATA,
    output logic      [`SDPF_BANKS-1:0] BANK_OPEN,
    output logic      [ROW_W-1:0]     MODE_WORD,
    output sdpf_pwr_type              PWR_MODE,
    output logic                      INBUF_EN
);

    localparam int NB = `SDPF_BANKS;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sdpf_cmd_if cmd_bus ();

    logic                cke_r;
    logic                cke_nxt;
    sdpf_pwr_type        pwr_r;
    sdpf_pwr_type        pwr_nxt;
    logic                inbuf_r;
    logic                inbuf_nxt;
    logic                ref_r;
    logic                ref_nxt;
    logic                clk_act;

    logic [NB-1:0]       open_r;
    logic [NB-1:0]       open_nxt;
    logic [ROW_W-1:0]    row_r   [NB];
    logic [ROW_W-1:0]    row_nxt [NB];
    logic [ROW_W-1:0]    mode_r;
    logic [ROW_W-1:0]    mode_nxt;

    logic                burst_r;
    logic                burst_nxt;
    logic                dir_wr_r;
    logic                dir_wr_nxt;
    logic                ap_r;
    logic                ap_nxt;
    logic [1:0]          bbank_r;
    logic [1:0]          bbank_nxt;
    logic [COL_W-1:0]    col_r;
    logic [COL_W-1:0]    col_nxt;
    logic [COL_W:0]      left_r;
    logic [COL_W:0]      left_nxt;
    logic [COL_W:0]      beats;
    logic [COL_W-1:0]    wrap_m;

    logic                beat;
    logic                beat_wr;
    logic [1:0]          beat_bank;
    logic [COL_W-1:0]    beat_col;
    logic                start;

    logic                rd_r;
    logic                rd_nxt;
    logic                wr_r;
    logic                wr_nxt;
    logic [1:0]          abank_r;
    logic [1:0]          abank_nxt;
    logic [ROW_W-1:0]    arow_r;
    logic [ROW_W-1:0]    arow_nxt;
    logic [COL_W-1:0]    acol_r;
    logic [COL_W-1:0]    acol_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Beats per burst from the mode word length code
    function automatic logic [COL_W:0] burst_beats(input logic [2:0] code);
        logic [COL_W:0] n;
        n = '0;
        case (code)
            `SDPF_BL_1:    n = (COL_W+1)'(1);
            `SDPF_BL_2:    n = (COL_W+1)'(2);
            `SDPF_BL_4:    n = (COL_W+1)'(4);
            `SDPF_BL_8:    n = (COL_W+1)'(8);
            `SDPF_BL_PAGE: n = (COL_W+1)'(1) << COL_W;
            default:       n = (COL_W+1)'(1);  // Reserved codes act as one beat
        endcase
        return n;
    endfunction : burst_beats

    // Next column, wrapping inside the burst boundary
    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c,
                                                  input logic [COL_W-1:0] m);
        logic [COL_W-1:0] inc;
        inc = c + 1'b1;
        return (c & ~m) | (inc & m);
    endfunction : next_col

    // ------------------------------------------------------------
    // Pin decoder
    // ------------------------------------------------------------
    sdpf_cmd_decode u_dec (
        .clk     (MCLK),
        .srst    (SRST),
        .cs_n    (CS_N),
        .ras_n   (RAS_N),
        .cas_n   (CAS_N),
        .we_n    (WE_N),
        .ba      (BA),
        .addr    (A),
        .cmd_bus (cmd_bus)
    );

    // clock acts only in run state
    assign clk_act         = (pwr_r == SDPF_RUN);
    assign cmd_bus.clk_act = clk_act;

    // ------------------------------------------------------------
    // Power mode from clock enable
    // ------------------------------------------------------------
    // Clock enable sampled like any pin; a state entered on a low
    // sample leaves on the first high sample, so the command on the
    // same edge is dropped and the next edge runs normally.
    always_comb begin
        // clock enable captured on the edge
        cke_nxt = CKE;
        pwr_nxt = pwr_r;
        case (pwr_r)
            SDPF_RUN: begin
                if (!cke_r) begin
                    if (cmd_bus.cmd == SDPF_REF && open_r == '0) begin
                        pwr_nxt = SDPF_SELF_REF;
                    end else if (burst_r || start) begin
                        pwr_nxt = SDPF_SUSPEND;
                    end else if (|open_r) begin
                        pwr_nxt = SDPF_ACT_PD;
                    end else begin
                        pwr_nxt = SDPF_PRE_PD;
                    end
                end
            end
            SDPF_PRE_PD, SDPF_ACT_PD, SDPF_SELF_REF: begin
                if (cke_r) begin
                    pwr_nxt = SDPF_RUN;
                end
            end
            SDPF_SUSPEND: begin
                if (cke_r) begin
                    pwr_nxt = SDPF_RUN;
                end
            end
            default: pwr_nxt = SDPF_RUN;
        endcase
        // buffers off in power-down and self refresh
        inbuf_nxt = (pwr_nxt == SDPF_RUN) || (pwr_nxt == SDPF_SUSPEND);
        // Auto refresh only when not turning into self refresh
        ref_nxt = clk_act && cke_r && (cmd_bus.cmd == SDPF_REF);
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cke_r   <= 1'b1;   // Tied-high use needs no start-up step
            pwr_r   <= SDPF_RUN;
            inbuf_r <= 1'b1;
            ref_r   <= 1'b0;
        end else begin
            cke_r   <= cke_nxt;
            pwr_r   <= pwr_nxt;
            inbuf_r <= inbuf_nxt;
            ref_r   <= ref_nxt;
        end
    end

    // ------------------------------------------------------------
    // Banks, mode word and burst counter
    // ------------------------------------------------------------
    always_comb begin
        open_nxt   = open_r;
        row_nxt    = row_r;
        mode_nxt   = mode_r;
        burst_nxt  = burst_r;
        dir_wr_nxt = dir_wr_r;
        ap_nxt     = ap_r;
        bbank_nxt  = bbank_r;
        col_nxt    = col_r;
        left_nxt   = left_r;
        beats      = burst_beats(mode_r[`SDPF_BL_MSB:`SDPF_BL_LSB]);
        wrap_m     = COL_W'(beats - 1'b1);
        beat       = 1'b0;
        beat_wr    = dir_wr_r;
        beat_bank  = bbank_r;
        beat_col   = col_r;
        start      = (cmd_bus.cmd == SDPF_RD) || (cmd_bus.cmd == SDPF_WR);
        if (clk_act) begin
            case (cmd_bus.cmd)
                SDPF_ACT: begin
                    open_nxt[cmd_bus.bank] = 1'b1;
                    row_nxt[cmd_bus.bank]  = cmd_bus.addr;
                end
                SDPF_PRE: begin
                    if (cmd_bus.addr[`SDPF_AP_BIT]) begin
                        open_nxt = '0;
                    end else begin
                        open_nxt[cmd_bus.bank] = 1'b0;
                    end
                end
                SDPF_LMR: begin
                    mode_nxt = cmd_bus.addr;
                end
                default: begin
                end
            endcase
            if (start) begin
                beat       = 1'b1;
                beat_wr    = (cmd_bus.cmd == SDPF_WR);
                beat_bank  = cmd_bus.bank;
                beat_col   = cmd_bus.addr[COL_W-1:0];
                dir_wr_nxt = beat_wr;
                bbank_nxt  = cmd_bus.bank;
                ap_nxt     = cmd_bus.addr[`SDPF_AP_BIT];
                col_nxt    = next_col(beat_col, wrap_m);
                left_nxt   = beats - 1'b1;
                burst_nxt  = (beats != (COL_W+1)'(1));
                if (!burst_nxt && ap_nxt) begin
                    open_nxt[cmd_bus.bank] = 1'b0;
                end
            end else if (cmd_bus.cmd == SDPF_BST) begin
                burst_nxt = 1'b0;
            end else if (burst_r) begin
                beat     = 1'b1;
                col_nxt  = next_col(col_r, wrap_m);
                left_nxt = left_r - 1'b1;
                if (left_r == (COL_W+1)'(1)) begin
                    burst_nxt = 1'b0;
                    if (ap_r) begin
                        open_nxt[bbank_r] = (cmd_bus.cmd == SDPF_ACT) && (cmd_bus.bank == bbank_r);
                    end
                end
            end
        end
        // Array strobes for this beat
        rd_nxt    = beat && !beat_wr;
        wr_nxt    = beat && beat_wr;
        abank_nxt = beat ? beat_bank : abank_r;
        acol_nxt  = beat ? beat_col : acol_r;
        arow_nxt  = beat ? row_r[beat_bank] : arow_r;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            open_r   <= '0;
            row_r    <= '{default: '0};
            mode_r   <= '0;
            burst_r  <= 1'b0;
            dir_wr_r <= 1'b0;
            ap_r     <= 1'b0;
            bbank_r  <= 2'h0;
            col_r    <= '0;
            left_r   <= '0;
            rd_r     <= 1'b0;
            wr_r     <= 1'b0;
            abank_r  <= 2'h0;
            arow_r   <= '0;
            acol_r   <= '0;
        end else begin
            open_r   <= open_nxt;
            row_r    <= row_nxt;
            mode_r   <= mode_nxt;
            burst_r  <= burst_nxt;
            dir_wr_r <= dir_wr_nxt;
            ap_r     <= ap_nxt;
            bbank_r  <= bbank_nxt;
            col_r    <= col_nxt;
            left_r   <= left_nxt;
            rd_r     <= rd_nxt;
            wr_r     <= wr_nxt;
            abank_r  <= abank_nxt;
            arow_r   <= arow_nxt;
            acol_r   <= acol_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data lines and masks
    // ------------------------------------------------------------
    // Suspend stops new beats only; data already in the read
    // pipeline still drains, trading exact freeze for simplicity.
    sdpf_dq_mask #(
        .DQ_W (DQ_W)
    ) u_dq (
        .clk       (MCLK),
        .srst      (SRST),
        .mask_in   ({UPPER_BYTE_MASK, LOWER_BYTE_MASK}),
        .dq_in     (DQ_I),
        .rd_beat   (rd_nxt),
        .arr_rdata (ARR_RDATA),
        .dq_out    (DQ_O),
        .dq_oe     (DQ_OE),
        .wdata     (ARR_WDATA),
        .wbe       (ARR_WBE)
    );

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    assign ARR_RD    = rd_r;
    assign ARR_WR    = wr_r;
    assign ARR_REF   = ref_r;
    assign ARR_BANK  = abank_r;
    assign ARR_ROW   = arow_r;
    assign ARR_COL   = acol_r;
    assign BANK_OPEN = open_r;
    assign MODE_WORD = mode_r;
    assign PWR_MODE  = pwr_r;
    assign INBUF_EN  = inbuf_r;

endmodule : sdpf_front_end

`default_nettype wire

// ==== bench/sdpf_array_model.sv ====
// Behavioural array that answers read beats one cycle late
`timescale 1ns/10ps
`default_nettype none
module sdpf_array_model (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic [1:0]  bank,
    input  wire logic [8:0]  col,
    output logic      [15:0] rdata
);
    logic [15:0] rdata_nxt;
    // Idle cycles toggle so a stale word never looks valid
    always_comb rdata_nxt = rd ? {bank, 5'h15, col} : ~rdata;
    always_ff @(posedge clk) rdata <= rdata_nxt;
endmodule : sdpf_array_model
`default_nettype wire

// ==== bench/sdpf_front_end_chk.sv ====
// Port checker for the DRAM pin front end
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"
module sdpf_front_end_chk
    import sdpf_pkg::*;
#(parameter int ROW_W = 13, parameter int DQ_W = 16)(
    input wire logic MCLK, SRST, CKE, CS_N, RAS_N, CAS_N, WE_N,
    input wire logic [1:0] BA,
    input wire logic [ROW_W-1:0] A,
    input wire logic LOWER_BYTE_MASK, UPPER_BYTE_MASK, ARR_WR, INBUF_EN,
    input wire logic [DQ_W/8-1:0] DQ_OE, ARR_WBE,
    input wire logic [3:0] BANK_OPEN,
    input wire logic [ROW_W-1:0] MODE_WORD,
    input wire sdpf_pwr_type PWR_MODE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    // Command taken while the clock acts on both edges
    sequence s_load;
        {CS_N, RAS_N, CAS_N, WE_N} == `SDPF_CODE_LMR && PWR_MODE == SDPF_RUN ##1 PWR_MODE == SDPF_RUN;
    endsequence
    sequence s_open;
        {CS_N, RAS_N, CAS_N, WE_N} == `SDPF_CODE_ACT && PWR_MODE == SDPF_RUN ##1 PWR_MODE == SDPF_RUN;
    endsequence
    AST_INBUF: assert property (INBUF_EN == !(PWR_MODE inside {SDPF_PRE_PD, SDPF_ACT_PD, SDPF_SELF_REF})) else $error("input buffer state wrong");
    AST_CKE_LOW: assert property (PWR_MODE == SDPF_RUN && !CKE |-> ##2 PWR_MODE != SDPF_RUN) else $error("clock not stopped");
    AST_CKE_STAY: assert property (!CKE [*2] ##0 PWR_MODE != SDPF_RUN |=> $stable(PWR_MODE)) else $error("low power left early");
    AST_DQM_OE: assert property ((DQ_OE & $past({UPPER_BYTE_MASK, LOWER_BYTE_MASK}, 3)) == 2'h0) else $error("masked lane driven");
    AST_WBE: assert property (ARR_WR |-> ARR_WBE == ~$past({UPPER_BYTE_MASK, LOWER_BYTE_MASK}, 2)) else $error("write enables wrong");
    AST_CS: assert property (CS_N |-> ##2 $stable(MODE_WORD)) else $error("deselected command acted");
    AST_LMR: assert property (s_load |-> ##1 MODE_WORD == $past(A, 2)) else $error("mode word wrong");
    AST_ACT: assert property (s_open |-> ##1 BANK_OPEN[$past(BA, 2)]) else $error("bank not opened");
endmodule : sdpf_front_end_chk
bind sdpf_front_end sdpf_front_end_chk #(.ROW_W(ROW_W), .DQ_W(DQ_W)) i_chk (.MCLK(MCLK), .SRST(SRST),
    .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .A(A),
    .LOWER_BYTE_MASK(LOWER_BYTE_MASK), .UPPER_BYTE_MASK(UPPER_BYTE_MASK), .ARR_WR(ARR_WR),
    .INBUF_EN(INBUF_EN), .DQ_OE(DQ_OE), .ARR_WBE(ARR_WBE), .BANK_OPEN(BANK_OPEN),
    .MODE_WORD(MODE_WORD), .PWR_MODE(PWR_MODE));
`default_nettype wire

// ==== bench/sdpf_front_end_tb.sv ====
// Self-checking bench for the DRAM pin front end
`timescale 1ns/10ps
`default_nettype none
`include "sdpf_consts.svh"
module sdpf_front_end_tb;
    import sdpf_pkg::*;
    // clock enable rests high outside power tests
    logic mclk = 1'b0, srst = 1'b1, cke = 1'b1, rd, inbuf, arr_ref;
    logic [3:0] pins = 4'hf, bank_open;
    logic [1:0] ba = 2'h0, msk = 2'h0, dq_oe, wbe, bank;
    logic [12:0] a = 13'h0000, mode_word, row;
    logic [15:0] dq_i = 16'h0000, dq_o, wdata, rdata;
    logic [8:0] col;
    sdpf_pwr_type pwr;
    int fail_count = 0;
    int compares = 0;
    always #5 mclk = ~mclk;
    sdpf_front_end i_dut (.MCLK(mclk), .SRST(srst), .CKE(cke), .CS_N(pins[3]), .RAS_N(pins[2]),
        .CAS_N(pins[1]), .WE_N(pins[0]), .BA(ba), .A(a), .LOWER_BYTE_MASK(msk[0]),
        .UPPER_BYTE_MASK(msk[1]), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .ARR_RD(rd), .ARR_WR(),
        .ARR_REF(arr_ref), .ARR_BANK(bank), .ARR_ROW(row), .ARR_COL(col), .ARR_WDATA(wdata),
        .ARR_RDATA(rdata), .BANK_OPEN(bank_open), .MODE_WORD(mode_word), .PWR_MODE(pwr),
        .ARR_WBE(wbe), .INBUF_EN(inbuf));
    sdpf_array_model i_arr (.clk(mclk), .rd(rd), .bank(bank), .col(col), .rdata(rdata));
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One command cycle from a falling edge, then deselect
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] ad);
        pins = c;
        ba = b;
        a = ad;
        tick(1);
        pins = 4'hf;
    endtask : cmd
    task automatic finish_test;
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    initial begin
        tick(8);
        srst = 1'b0;
        cmd(`SDPF_CODE_LMR, 2'h0, 13'h0001);
        tick(1);
        chk("mode word", 16'(mode_word), 16'h0001);
        cmd(4'h8, 2'h0, 13'h0003);
        tick(1);
        chk("deselected load", 16'(mode_word), 16'h0001);
        cmd(`SDPF_CODE_ACT, 2'h2, 13'h1abc);
        tick(1);
        chk("bank open", 16'(bank_open), 16'h0004);
        // Second beat carries the upper byte mask
        dq_i = 16'h1234;
        cmd(`SDPF_CODE_WR, 2'h2, 13'h0004);
        dq_i = 16'habcd;
        msk = 2'h2;
        tick(1);
        chk("beat0 data", wdata, 16'h1234);
        chk("beat0 enables", 16'(wbe), 16'h0003);
        chk("beat0 row", 16'(row), 16'h1abc);
        msk = 2'h0;
        tick(1);
        chk("beat1 col", 16'(col), 16'h0005);
        chk("beat1 enables", 16'(wbe), 16'h0001);
        chk("beat1 data", wdata, 16'habcd);
        cmd(`SDPF_CODE_RD, 2'h2, 13'h0004);
        msk = 2'h1;
        tick(1);
        msk = 2'h0;
        tick(2);
        chk("read beat0", dq_o, {2'h2, 5'h15, 9'h004});
        chk("lanes beat0", 16'(dq_oe), 16'h0002);
        tick(1);
        chk("read beat1", dq_o, {2'h2, 5'h15, 9'h005});
        chk("lanes beat1", 16'(dq_oe), 16'h0003);
        cke = 1'b0;
        tick(2);
        chk("row open stop", 16'(pwr), 16'(SDPF_ACT_PD));
        chk("buffers off", 16'(inbuf), 16'h0000);
        cke = 1'b1;
        tick(2);
        chk("wake", 16'(pwr), 16'(SDPF_RUN));
        cke = 1'b0;
        cmd(`SDPF_CODE_RD, 2'h2, 13'h0004);
        tick(1);
        chk("suspend", 16'(pwr), 16'(SDPF_SUSPEND));
        chk("buffers on in suspend", 16'(inbuf), 16'h0001);
        cke = 1'b1;
        tick(2);
        chk("suspended col", 16'(col), 16'h0004);
        tick(1);
        chk("resumed col", 16'(col), 16'h0005);
        cmd(`SDPF_CODE_PRE, 2'h0, 13'h0400);
        tick(1);
        chk("precharge all", 16'(bank_open), 16'h0000);
        cmd(`SDPF_CODE_REF, 2'h0, 13'h0000);
        tick(1);
        chk("auto refresh", 16'(arr_ref), 16'h0001);
        cke = 1'b0;
        tick(2);
        chk("idle stop", 16'(pwr), 16'(SDPF_PRE_PD));
        cke = 1'b1;
        tick(2);
        cke = 1'b0;
        cmd(`SDPF_CODE_REF, 2'h0, 13'h0000);
        tick(1);
        chk("self refresh", 16'(pwr), 16'(SDPF_SELF_REF));
        chk("no auto refresh", 16'(arr_ref), 16'h0000);
        tick(1);
        chk("self refresh held", 16'(pwr), 16'(SDPF_SELF_REF));
        cke = 1'b1;
        tick(2);
        chk("wake again", 16'(pwr), 16'(SDPF_RUN));
        finish_test();
    end
endmodule : sdpf_front_end_tb
`default_nettype wire
